// ===== src/tpl_pkg.sv
// Constants, types and register layout for the TDM port layer-one control block
// Behaviour
// [RULE1] Receive bits 0-2 invert clock, data, sync
// [RULE2] Transmit bits 0-2 invert clock, data, sync
// [RULE3] Detector reset bit high then low restarts
// [RULE4] Receive sync advance: none, half, one, two
// [RULE5] Receive format picks 193/256/512/1024 clock frames
// [RULE6] Transmit sync advance: none, half, one, two
// [RULE7] Transmit format picks 193/256/512/1024 clock frames
// [RULE8] Receive bypass to fast engine, ports 0-1
// [RULE9] Transmit bypass from fast engine, ports 0-1
// [RULE10] Receive unframed bit ignores timeslots and sync
// [RULE11] Transmit unframed overrides per-slot enables
// [RULE12] Local loop sends transmit data into receive
// [RULE13] Line loop echoes receive data to output
// [RULE14] Force-ones bit low holds output at one
// [RULE15] Unframed transmit source: engine or tester
// [RULE16] Search timeout bit shows live detector status
// [RULE17] Loop-up bit shows detector verdict live
// [RULE18] Receive sync off frame start latches flag
// [RULE19] Transmit sync off frame start latches flag
// [RULE20] Bit 14 enables each misalign interrupt
// [RULE21] Controls reset to zero; status bits read-only
// [RULE22] Partner gives 8 kHz sync or low; the bench line model syncs at about 3 to 16 kHz
// [RULE23] Misalign during read keeps flag set
package tpl_pkg;

    // Register byte addresses
    localparam logic [11:0] TPL_RX_CTRL_ADDR = 12'h000;
    localparam logic [11:0] TPL_TX_CTRL_ADDR = 12'h004;
    localparam logic [15:0] TPL_CTRL_RESET   = 16'h0000;

    // Receive control fields
    localparam int RX_CLK_INV   = 0;
    localparam int RX_DAT_INV   = 1;
    localparam int RX_SYN_INV   = 2;
    localparam int RX_DET_RST   = 3;
    localparam int RX_ADV_LO    = 4;
    localparam int RX_FMT_LO    = 6;
    localparam int RX_FAST      = 8;
    localparam int RX_UNFRAMED  = 9;
    localparam int RX_LOCAL_LP  = 10;
    localparam int RX_TIMEOUT   = 12;
    localparam int RX_LOOP_UP   = 13;
    localparam int RX_IRQ_EN    = 14;
    localparam int RX_MISALIGN  = 15;
    localparam logic [15:0] RX_WR_MASK = 16'h47ff;

    // Transmit control fields
    localparam int TX_CLK_INV   = 0;
    localparam int TX_DAT_INV   = 1;
    localparam int TX_SYN_INV   = 2;
    localparam int TX_ONES_N    = 3;
    localparam int TX_ADV_LO    = 4;
    localparam int TX_FMT_LO    = 6;
    localparam int TX_FAST      = 8;
    localparam int TX_UNFRAMED  = 9;
    localparam int TX_LINE_LP   = 10;
    localparam int TX_PAT_SRC   = 11;
    localparam int TX_IRQ_EN    = 14;
    localparam int TX_MISALIGN  = 15;
    localparam logic [15:0] TX_WR_MASK = 16'h4fff;

    // Frame lengths in link clocks
    localparam logic [10:0] FRAME_T1   = 11'd193;
    localparam logic [10:0] FRAME_E1   = 11'd256;
    localparam logic [10:0] FRAME_4M   = 11'd512;
    localparam logic [10:0] FRAME_8M   = 11'd1024;

    // Sync advance codes
    localparam logic [1:0] ADV_NONE = 2'b00;
    localparam logic [1:0] ADV_HALF = 2'b01;
    localparam logic [1:0] ADV_ONE  = 2'b10;
    localparam logic [1:0] ADV_TWO  = 2'b11;

    typedef enum logic [1:0] {
        SYNC_HUNT = 2'b01,
        SYNC_LOCK = 2'b10
    } tpl_sync_e;

    typedef logic [9:0] tpl_bit_t;

endpackage

// ===== src/tpl_port.sv
// Layer-one control for one serial TDM port, with APB register access
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module tpl_port #(
    parameter int PORT_INDEX = 0
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Line pins
    input  wire logic        rx_clock_pin,
    input  wire logic        rx_data_pin,
    input  wire logic        rx_frame_sync_pin,
    input  wire logic        tx_clock_pin,
    input  wire logic        tx_frame_sync_pin,
    output logic             tx_serial_out,
    // Slow engine receive side
    output logic             rx_bit_valid,
    output logic             rx_bit_data,
    output tpl_pkg::tpl_bit_t rx_bit_index,
    // Fast engine receive side
    output logic             fast_rx_valid,
    output logic             fast_rx_data,
    // Transmit sources
    input  wire logic        hdlc_tx_data,
    input  wire logic        fast_tx_data,
    input  wire logic        bert_tx_data,
    input  wire logic        tx_slot_enable,
    output logic             tx_bit_take,
    output logic             fast_tx_take,
    output tpl_pkg::tpl_bit_t tx_bit_index,
    // Loop pattern detector
    output logic             loop_detector_restart,
    input  wire logic        loop_search_timeout,
    input  wire logic        loop_up_detected,
    // Misalignment interrupt requests
    output logic             rx_misalign_irq,
    output logic             tx_misalign_irq
);
    import tpl_pkg::*;

    localparam logic HAS_FAST = (PORT_INDEX < 2);

    function automatic logic [10:0] frame_len(input logic [1:0] fmt);
        case (fmt)
            2'b00:   frame_len = FRAME_T1;
            2'b01:   frame_len = FRAME_E1;
            2'b10:   frame_len = FRAME_4M;
            default: frame_len = FRAME_8M;
        endcase
    endfunction

    // Bit index at which the sync is expected, given advance
    function automatic tpl_bit_t sync_pos(input logic [1:0] fmt, input logic [1:0] adv);
        logic [10:0] len;
        len = frame_len(fmt);
        case (adv)
            ADV_ONE: sync_pos = tpl_bit_t'(len - 11'd1);
            ADV_TWO: sync_pos = tpl_bit_t'(len - 11'd2);
            default: sync_pos = '0;
        endcase
    endfunction

    function automatic tpl_bit_t next_bit(input tpl_bit_t idx, input logic [1:0] fmt);
        if ({1'b0, idx} == frame_len(fmt) - 11'd1) begin
            next_bit = '0;
        end else begin
            next_bit = idx + tpl_bit_t'(1);
        end
    endfunction

    // Reset release
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Pin synchronisers; link clock runs far below core_clk
    logic [4:0] pin_meta_q;
    logic [4:0] pin_sync_q;
    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= {tx_frame_sync_pin, tx_clock_pin, rx_frame_sync_pin, rx_data_pin, rx_clock_pin};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Control registers
    logic [15:0] rx_ctrl_q;
    logic [15:0] tx_ctrl_q;
    logic        rx_flag_q;
    logic        tx_flag_q;
    logic        rx_misalign;
    logic        tx_misalign;

    logic wr_acc;
    logic rd_acc;
    logic hit_rx;
    logic hit_tx;
    assign wr_acc  = psel && penable && pwrite;
    assign rd_acc  = psel && penable && !pwrite;
    assign hit_rx  = (paddr == TPL_RX_CTRL_ADDR);
    assign hit_tx  = (paddr == TPL_TX_CTRL_ADDR);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit_rx && !hit_tx;

    // Only writable bits are stored; bit 8 exists on fast ports only
    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rx_ctrl_q <= TPL_CTRL_RESET; // see [RULE21]
            tx_ctrl_q <= TPL_CTRL_RESET; // see [RULE21]
        end else begin
            if (wr_acc && hit_rx) begin
                rx_ctrl_q <= pwdata[15:0] & RX_WR_MASK & ~(16'(!HAS_FAST) << RX_FAST); // see [RULE21]
            end
            if (wr_acc && hit_tx) begin
                tx_ctrl_q <= pwdata[15:0] & TX_WR_MASK & ~(16'(!HAS_FAST) << TX_FAST); // see [RULE21]
            end
        end
    end

    // Restart pulse on the falling write of the detector reset bit
    logic det_rst_prev_q;
    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            det_rst_prev_q        <= 1'b0;
            loop_detector_restart <= 1'b0;
        end else begin
            det_rst_prev_q        <= rx_ctrl_q[RX_DET_RST];
            loop_detector_restart <= det_rst_prev_q && !rx_ctrl_q[RX_DET_RST]; // see [RULE3]
        end
    end

    // Misalignment flags: clear on read, a new event wins
    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rx_flag_q <= 1'b0;
            tx_flag_q <= 1'b0;
        end else begin
            if (rx_misalign) begin
                rx_flag_q <= 1'b1; // see [RULE18] see [RULE23]
            end else if (rd_acc && hit_rx) begin
                rx_flag_q <= 1'b0; // see [RULE18]
            end
            if (tx_misalign) begin
                tx_flag_q <= 1'b1; // see [RULE19] see [RULE23]
            end else if (rd_acc && hit_tx) begin
                tx_flag_q <= 1'b0; // see [RULE19]
            end
        end
    end

    assign rx_misalign_irq = rx_flag_q && rx_ctrl_q[RX_IRQ_EN]; // see [RULE20]
    assign tx_misalign_irq = tx_flag_q && tx_ctrl_q[TX_IRQ_EN]; // see [RULE20]

    // Read data; the status bits come from live inputs and flags
    logic [15:0] rx_view;
    logic [15:0] tx_view;
    always_comb begin
        rx_view               = rx_ctrl_q;
        rx_view[RX_TIMEOUT]   = loop_search_timeout; // see [RULE16]
        rx_view[RX_LOOP_UP]   = loop_up_detected;    // see [RULE17]
        rx_view[RX_MISALIGN]  = rx_flag_q;
        tx_view               = tx_ctrl_q;
        tx_view[TX_MISALIGN]  = tx_flag_q;
    end

    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == TPL_RX_CTRL_ADDR) begin
                prdata <= {16'h0000, rx_view};
            end else if (paddr == TPL_TX_CTRL_ADDR) begin
                prdata <= {16'h0000, tx_view};
            end else begin
                prdata <= '0;
            end
        end
    end

    // Receive link edges after optional inversion
    logic rx_clk_eff;
    logic rx_clk_prev_q;
    logic rx_rise;
    logic rx_fall;
    logic rx_sync_eff;
    assign rx_clk_eff  = pin_sync_q[0] ^ rx_ctrl_q[RX_CLK_INV]; // see [RULE1]
    assign rx_sync_eff = pin_sync_q[2] ^ rx_ctrl_q[RX_SYN_INV]; // see [RULE1]
    assign rx_rise     = rx_clk_eff && !rx_clk_prev_q;
    assign rx_fall     = !rx_clk_eff && rx_clk_prev_q;

    // Transmit link edges after optional inversion
    logic tx_clk_eff;
    logic tx_clk_prev_q;
    logic tx_rise;
    logic tx_fall;
    logic tx_sync_eff;
    assign tx_clk_eff  = pin_sync_q[3] ^ tx_ctrl_q[TX_CLK_INV]; // see [RULE2]
    assign tx_sync_eff = pin_sync_q[4] ^ tx_ctrl_q[TX_SYN_INV]; // see [RULE2]
    assign tx_rise     = tx_clk_eff && !tx_clk_prev_q;
    assign tx_fall     = !tx_clk_eff && tx_clk_prev_q;

    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rx_clk_prev_q <= 1'b0;
            tx_clk_prev_q <= 1'b0;
        end else begin
            rx_clk_prev_q <= rx_clk_eff;
            tx_clk_prev_q <= tx_clk_eff;
        end
    end

    // Receive frame tracking
    logic [1:0] rx_fmt;
    logic [1:0] rx_adv;
    logic       rx_unframed;
    assign rx_fmt      = rx_ctrl_q[RX_FMT_LO +: 2];
    assign rx_adv      = rx_ctrl_q[RX_ADV_LO +: 2];
    assign rx_unframed = rx_ctrl_q[RX_UNFRAMED];

    tpl_sync_e rx_state_q;
    tpl_bit_t  rx_cnt_q;
    logic      rx_half_q;
    logic      rx_sync_hit;
    tpl_bit_t  rx_exp;
    assign rx_exp      = sync_pos(rx_fmt, rx_adv); // see [RULE4] see [RULE5]
    // Half-clock advance: sync caught on the falling edge, checked at the next rise
    assign rx_sync_hit = (rx_adv == ADV_HALF) ? rx_half_q : rx_sync_eff; // see [RULE4]
    assign rx_misalign = rx_rise && !rx_unframed && rx_sync_hit
                         && (rx_state_q == SYNC_LOCK) && (rx_cnt_q != rx_exp); // see [RULE18]

    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rx_state_q <= SYNC_HUNT;
            rx_cnt_q   <= '0;
            rx_half_q  <= 1'b0;
        end else if (rx_unframed) begin
            rx_state_q <= SYNC_HUNT; // see [RULE10]
            rx_cnt_q   <= '0;
            rx_half_q  <= 1'b0;
        end else begin
            if (rx_fall) begin
                rx_half_q <= rx_sync_eff;
            end
            if (rx_rise) begin
                if (rx_sync_hit) begin
                    rx_state_q <= SYNC_LOCK;
                    rx_cnt_q   <= next_bit(rx_exp, rx_fmt); // see [RULE5]
                end else begin
                    case (rx_state_q)
                        SYNC_LOCK: rx_cnt_q <= next_bit(rx_cnt_q, rx_fmt); // see [RULE5]
                        SYNC_HUNT: rx_cnt_q <= '0;
                        default:   rx_state_q <= SYNC_HUNT;
                    endcase
                end
            end
        end
    end

    // Receive data path and engine delivery
    logic tx_line_bit_q;
    logic rx_bit_in;
    logic rx_fast_on;
    assign rx_fast_on = HAS_FAST && rx_ctrl_q[RX_FAST];
    // Local loop replaces line data with what is being sent
    assign rx_bit_in  = rx_ctrl_q[RX_LOCAL_LP] ? tx_line_bit_q
                                               : (pin_sync_q[1] ^ rx_ctrl_q[RX_DAT_INV]); // see [RULE12] see [RULE1]

    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rx_bit_valid  <= 1'b0;
            rx_bit_data   <= 1'b0;
            rx_bit_index  <= '0;
            fast_rx_valid <= 1'b0;
            fast_rx_data  <= 1'b0;
        end else begin
            // Slow path only sees framed bits once aligned, or every bit unframed
            rx_bit_valid  <= rx_rise && !rx_fast_on
                             && (rx_unframed || rx_state_q == SYNC_LOCK || rx_sync_hit); // see [RULE8] see [RULE10]
            fast_rx_valid <= rx_rise && rx_fast_on; // see [RULE8]
            if (rx_rise) begin
                rx_bit_data  <= rx_bit_in;
                fast_rx_data <= rx_bit_in;
                rx_bit_index <= rx_unframed ? '0 : (rx_sync_hit ? rx_exp : rx_cnt_q);
            end
        end
    end

    // Transmit frame tracking
    logic [1:0] tx_fmt;
    logic [1:0] tx_adv;
    logic       tx_unframed;
    assign tx_fmt      = tx_ctrl_q[TX_FMT_LO +: 2];
    assign tx_adv      = tx_ctrl_q[TX_ADV_LO +: 2];
    assign tx_unframed = tx_ctrl_q[TX_UNFRAMED];

    tpl_sync_e tx_state_q;
    tpl_bit_t  tx_cnt_q;
    logic      tx_half_q;
    logic      tx_sync_hit;
    tpl_bit_t  tx_exp;
    assign tx_exp      = sync_pos(tx_fmt, tx_adv); // see [RULE6] see [RULE7]
    assign tx_sync_hit = (tx_adv == ADV_HALF) ? tx_half_q : tx_sync_eff; // see [RULE6]
    assign tx_misalign = tx_rise && !tx_unframed && tx_sync_hit
                         && (tx_state_q == SYNC_LOCK) && (tx_cnt_q != tx_exp); // see [RULE19]

    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            tx_state_q <= SYNC_HUNT;
            tx_cnt_q   <= '0;
            tx_half_q  <= 1'b0;
        end else if (tx_unframed) begin
            tx_state_q <= SYNC_HUNT; // see [RULE11]
            tx_cnt_q   <= '0;
            tx_half_q  <= 1'b0;
        end else begin
            if (tx_fall) begin
                tx_half_q <= tx_sync_eff;
            end
            if (tx_rise) begin
                if (tx_sync_hit) begin
                    tx_state_q <= SYNC_LOCK;
                    tx_cnt_q   <= next_bit(tx_exp, tx_fmt); // see [RULE7]
                end else begin
                    case (tx_state_q)
                        SYNC_LOCK: tx_cnt_q <= next_bit(tx_cnt_q, tx_fmt); // see [RULE7]
                        SYNC_HUNT: tx_cnt_q <= '0;
                        default:   tx_state_q <= SYNC_HUNT;
                    endcase
                end
            end
        end
    end

    // Transmit source selection, evaluated at the effective falling edge
    logic tx_fast_on;
    logic tx_src;
    assign tx_fast_on = HAS_FAST && tx_ctrl_q[TX_FAST];
    always_comb begin
        if (tx_fast_on) begin
            tx_src = fast_tx_data; // see [RULE9]
        end else if (tx_ctrl_q[TX_LINE_LP]) begin
            // Line loop is only safe at slow-engine rates
            tx_src = pin_sync_q[1] ^ rx_ctrl_q[RX_DAT_INV]; // see [RULE13]
        end else if (tx_unframed) begin
            tx_src = tx_ctrl_q[TX_PAT_SRC] ? bert_tx_data : hdlc_tx_data; // see [RULE15] see [RULE11]
        end else if (tx_slot_enable && tx_state_q == SYNC_LOCK) begin
            tx_src = hdlc_tx_data;
        end else begin
            tx_src = 1'b1; // Idle slots and unaligned frames send ones
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            tx_line_bit_q <= 1'b1;
            tx_serial_out <= 1'b1; // see [RULE14]
            tx_bit_take   <= 1'b0;
            fast_tx_take  <= 1'b0;
            tx_bit_index  <= '0;
        end else begin
            tx_bit_take  <= tx_fall && !tx_fast_on && !tx_ctrl_q[TX_LINE_LP]; // see [RULE9]
            fast_tx_take <= tx_fall && tx_fast_on; // see [RULE9]
            if (tx_fall) begin
                tx_line_bit_q <= tx_src;
                tx_bit_index  <= tx_cnt_q;
                if (!tx_ctrl_q[TX_ONES_N]) begin
                    tx_serial_out <= 1'b1; // see [RULE14]
                end else begin
                    tx_serial_out <= tx_src ^ tx_ctrl_q[TX_DAT_INV]; // see [RULE2]
                end
            end
        end
    end

endmodule // tpl_port

// ===== verif/tpl_port_props.sv
// Port-level assertions for the layer-one port control block
`timescale 1ns/1ps
module tpl_port_props
    import tpl_pkg::*;
#(
    parameter int PORT_INDEX = 0
) (
    // Clock, reset and register bus
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Engine strobes
    input wire logic        rx_bit_valid,
    input wire logic        fast_rx_valid,
    input wire logic        tx_bit_take,
    input wire logic        fast_tx_take,
    // Detector and requests
    input wire logic        loop_detector_restart,
    input wire logic        loop_search_timeout,
    input wire logic        loop_up_detected,
    input wire logic        rx_misalign_irq,
    input wire logic        tx_misalign_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic rx_acc;
    logic tx_acc;
    logic clr_wr;
    assign rx_acc = psel && penable && paddr == TPL_RX_CTRL_ADDR;
    assign tx_acc = psel && penable && paddr == TPL_TX_CTRL_ADDR;
    assign clr_wr = rx_acc && pwrite && !pwdata[RX_DET_RST];

    a_slverr_map: assert property (psel && penable |-> pslverr == !(rx_acc || tx_acc))
        else $error("bad slave error");
    a_read_upper: assert property (psel && penable && !pwrite
        |-> prdata[31:16] == 16'h0 && (!pslverr || prdata == 32'h0))
        else $error("read not zero");
    a_status_live: assert property (rx_acc && !pwrite
        |-> prdata[13:12] == {$past(loop_up_detected), $past(loop_search_timeout)})
        else $error("status not live");
    a_restart_cause: assert property (loop_detector_restart |->
        ($past(clr_wr) || $past(clr_wr, 2) || $past(clr_wr, 3)) ##1 !loop_detector_restart)
        else $error("stray restart");
    a_rx_irq_clear: assert property ($fell(rx_misalign_irq) |-> $past(rx_acc))
        else $error("rx irq dropped");
    a_tx_irq_clear: assert property ($fell(tx_misalign_irq) |-> $past(tx_acc))
        else $error("tx irq dropped");
    a_rx_bit_gap: assert property (rx_bit_valid |=> !rx_bit_valid [*4])
        else $error("rx strobes close");
    a_tx_take_gap: assert property (tx_bit_take |=> !tx_bit_take [*4])
        else $error("tx takes close");
    a_fast_only: assert property ((fast_rx_valid || fast_tx_take)
        |-> PORT_INDEX < 2 && !(fast_rx_valid && rx_bit_valid) && !(fast_tx_take && tx_bit_take))
        else $error("fast beside slow");
endmodule // tpl_port_props

// ===== verif/tpl_line_model.sv
// Line-side partner: serial clock, frame sync and data for one direction
`timescale 1ns/1ps
module tpl_line_model #(
    parameter int PHASE = 7
) (
    // Bench control
    input  wire logic run,
    input  wire logic framed,
    input  wire logic level,
    input  int        period,
    // Line pins
    output logic      lclk,
    output logic      sync,
    output logic      data
);
    int cnt;
    initial begin
        lclk = 1'b0;
        sync = 1'b0;
        data = 1'b0;
        cnt = 0;
        #PHASE;
        forever begin
            #160;
            if (run) begin
                lclk = ~lclk;
            end else begin
                data = ~data;  // Idle data toggles
            end
            if (run && !lclk) begin
                cnt = (cnt >= period - 1) ? 0 : cnt + 1;
                sync = framed && cnt == 0;
                data = level;
            end
        end
    end
endmodule // tpl_line_model

// ===== verif/test_tpl_port.sv
// Self-checking bench for the port control block
`timescale 1ns/1ps
module test_tpl_port;
    import tpl_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, rerr, tx_serial_out;
    logic        rx_clock_pin, rx_data_pin, rx_frame_sync_pin, tx_clock_pin, tx_frame_sync_pin;
    logic        rx_bit_valid, rx_bit_data, fast_rx_valid, fast_rx_data, tx_bit_take, fast_tx_take;
    logic        hdlc_tx_data = 1'b0, fast_tx_data = 1'b0, bert_tx_data = 1'b0, tx_slot_enable = 1'b1;
    logic        loop_detector_restart, loop_search_timeout = 1'b0, loop_up_detected = 1'b0;
    logic        rx_misalign_irq, tx_misalign_irq;
    tpl_bit_t    rx_bit_index, tx_bit_index;
    logic        run_m [2] = '{1'b0, 1'b0};
    logic        frm_m [2] = '{1'b0, 1'b0};
    logic        lvl_m [2] = '{1'b1, 1'b0};
    int          per_m [2] = '{193, 193};
    int          miscompares = 0;
    int          total_checks = 0;

    always #20 core_clk = ~core_clk;

    tpl_port dut_u (.*);
    tpl_line_model #(.PHASE(7)) rx_line_u (.run(run_m[0]), .framed(frm_m[0]), .level(lvl_m[0]),
        .period(per_m[0]), .lclk(rx_clock_pin), .sync(rx_frame_sync_pin), .data(rx_data_pin));
    tpl_line_model #(.PHASE(93)) tx_line_u (.run(run_m[1]), .framed(frm_m[1]), .level(lvl_m[1]),
        .period(per_m[1]), .lclk(tx_clock_pin), .sync(tx_frame_sync_pin), .data());

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp, what);
    endtask

    task automatic sync_wait(input int k);
        if (k != 0) @(posedge tx_frame_sync_pin);
        else @(posedge rx_frame_sync_pin);
        repeat (16) @(posedge core_clk);
    endtask

    task automatic t_regs();
        logic seen;
        seen = 1'b0;
        rd_chk(TPL_RX_CTRL_ADDR, 32'h0, "rx reset");
        rd_chk(TPL_TX_CTRL_ADDR, 32'h0, "tx reset");
        chk(tx_serial_out, 1'b1, "reset ones");
        loop_search_timeout <= 1'b1;
        apb(1'b1, TPL_RX_CTRL_ADDR, 32'hffff_ffff);
        rd_chk(TPL_RX_CTRL_ADDR, {16'h0, RX_WR_MASK | 16'h1000}, "rx bits");
        apb(1'b1, TPL_RX_CTRL_ADDR, 32'h0);
        for (int n = 0; n < 6; n++) begin
            @(posedge core_clk);
            seen = seen | (loop_detector_restart === 1'b1);
        end
        chk(seen, 1'b1, "restart");
        loop_search_timeout <= 1'b0;
        loop_up_detected <= 1'b1;
        rd_chk(TPL_RX_CTRL_ADDR, 32'h2000, "loop-up");
        loop_up_detected <= 1'b0;
        apb(1'b1, TPL_TX_CTRL_ADDR, 32'hffff);
        rd_chk(TPL_TX_CTRL_ADDR, {16'h0, TX_WR_MASK}, "tx bits");
        apb(1'b1, 12'h008, 32'hffff);
        chk(rerr, 1'b1, "bad write");
        rd_chk(12'h008, 32'h0, "bad read");
        $display("regs done");
    endtask

    // Unframed tx sources, line rate under loop limit
    task automatic t_tx();
        logic [15:0] c [6] = '{16'h0200, 16'h0a08, 16'h0a0a, 16'h0308, 16'h0608, 16'h0208};
        logic [2:0]  s [6] = '{3'b000, 3'b010, 3'b010, 3'b100, 3'b000, 3'b010};
        logic        e [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 6; i++) begin
            {fast_tx_data, bert_tx_data, hdlc_tx_data} <= s[i];
            apb(1'b1, TPL_TX_CTRL_ADDR, {16'h0, c[i]});
            repeat (48) @(posedge core_clk);
            chk(tx_serial_out, e[i], "tx output");
        end
        $display("tx done");
    endtask

    // Line sends ones, loop sends zero
    task automatic t_rx();
        logic [15:0] c [4] = '{16'h0200, 16'h0202, 16'h0600, 16'h0300};
        logic        e [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, TPL_RX_CTRL_ADDR, {16'h0, c[i]});
            repeat (48) @(posedge core_clk);
            for (int n = 0; n < 40; n++) begin
                @(posedge core_clk);
                if (rx_bit_valid === 1'b1 || fast_rx_valid === 1'b1) break;
            end
            chk(c[i][RX_FAST] ? fast_rx_valid : rx_bit_valid, 1'b1, "rx strobe");
            chk(c[i][RX_FAST] ? fast_rx_data : rx_bit_data, e[i], "rx bit");
        end
        $display("rx done");
    endtask

    task automatic t_align(input int k, input logic [1:0] f);
        logic [11:0] a;
        logic [31:0] v;
        a = (k != 0) ? TPL_TX_CTRL_ADDR : TPL_RX_CTRL_ADDR;
        v = {16'h0, 8'h40, f, f, k[0], 3'b000};
        per_m[k] = (f == 2'd0) ? FRAME_T1 : (f == 2'd1) ? FRAME_E1 : (f == 2'd2) ? FRAME_4M : FRAME_8M;
        frm_m[k] = 1'b1;
        apb(1'b1, a, v);
        run_m[k] = 1'b1;
        sync_wait(k);
        apb(1'b0, a, 32'h0);
        sync_wait(k);
        rd_chk(a, v, "aligned");
        per_m[k] = per_m[k] + 1;
        sync_wait(k);
        run_m[k] = 1'b0;
        chk((k != 0) ? tx_misalign_irq : rx_misalign_irq, 1'b1, "irq set");
        rd_chk(a, v | 32'h8000, "flag set");
        rd_chk(a, v, "flag clear");
        chk((k != 0) ? tx_misalign_irq : rx_misalign_irq, 1'b0, "irq clear");
        $display("align done");
    endtask

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_regs();
        run_m[0] = 1'b1;
        run_m[1] = 1'b1;
        t_tx();
        t_rx();
        for (int f = 0; f < 4; f++) t_align(0, f[1:0]);
        t_align(1, 2'b00);
        conclude();
    end

    // Frames take about 2 ms
    initial begin
        #4000000;
        miscompares++;
        $display("Error at %0t: run did not finish", $time);
        conclude();
    end
endmodule // test_tpl_port

bind tpl_port tpl_port_props #(.PORT_INDEX(PORT_INDEX)) props_u (.*);
